// *** src/pwm_output_stage.sv ***
// PWM output stage: auto-shutdown, restart, dead band and pulse steering.
// Assumes a period and duty generator supplies pwm_raw and period_start,
// and that all inputs are synchronous to clk.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pwm_output_stage
    import pwm_stage_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic pwm_raw,
    input wire logic period_start,
    input wire logic comparator_one_out,
    input wire logic comparator_two_out,
    input wire logic timer1_sync_tick,
    input wire logic ext_interrupt_pin,
    output logic pwm_out_a,
    output logic pwm_out_a_oe_n,
    output logic pwm_out_b,
    output logic pwm_out_b_oe_n,
    output logic pwm_out_c,
    output logic pwm_out_c_oe_n,
    output logic pwm_out_d,
    output logic pwm_out_d_oe_n
);

    // Next value of a dead-band counter: reload while the scheduled
    // output is inactive, count down on instruction-cycle ticks otherwise.
    function automatic logic [6:0] next_delay(
        input logic sched,
        input logic tick,
        input logic [6:0] count,
        input logic [6:0] reload
    );
        logic [6:0] result;
        result = count;
        if (!sched) begin
            result = reload;
        end else if (tick && (count != 7'h00)) begin
            result = count - 7'h01;
        end
        return result;
    endfunction : next_delay

    // Drive decision for a pin held in its shutdown state.
    // Bit 1 set floats the pin with its level at zero; otherwise bit 0
    // is the level driven onto the pin.
    function automatic logic [1:0] shutdown_drive(input logic [1:0] state);
        logic [1:0] result;
        result = 2'b00;
        unique case (state)
            2'b00: begin
                result = 2'b00;
            end
            2'b01: begin
                result = 2'b01;
            end
            2'b10, 2'b11: begin
                result = 2'b10;
            end
        endcase
        return result;
    endfunction : shutdown_drive

    logic [DATA_W-1:0] shutdown_control;
    logic [DATA_W-1:0] pwm_restart_deadband_control;
    logic [DATA_W-1:0] mode_control;
    logic [DATA_W-1:0] steering_control;
    logic comparator_two_sync;
    logic shutdown_event_status;
    logic run_enabled;
    logic [3:0] steer_active;
    logic [1:0] tcy_count;
    logic tcy_tick;
    logic comparator_two_held;
    logic comparator_two_eff;
    logic [6:0] delay_a;
    logic [6:0] delay_b;
    logic source_hit;
    logic shutdown_now;
    logic [2:0] shutdown_source_select;
    logic [1:0] pair_ac_shutdown_state;
    logic [1:0] pair_bd_shutdown_state;
    logic auto_restart_enable;
    logic [6:0] dead_band_count;
    logic [1:0] unit_mode_high_bits;
    logic [1:0] output_polarity_select;
    output_config_t output_configuration;
    logic steering_sync_select;
    logic pwm_on;
    logic [3:0] pin_used;
    logic [3:0] pin_active;
    logic [3:0] pin_level;
    logic [3:0] pin_oe_n;
    logic wr_shutdown;

    // Field views of the control registers.
    assign shutdown_source_select = shutdown_control[SD_SELECT_LSB +: 3];
    assign pair_ac_shutdown_state = shutdown_control[PAIR_AC_LSB +: 2];
    assign pair_bd_shutdown_state = shutdown_control[PAIR_BD_LSB +: 2];
    assign auto_restart_enable = pwm_restart_deadband_control[RESTART_BIT];
    assign dead_band_count = pwm_restart_deadband_control[DEADBAND_LSB +: 7];
    assign unit_mode_high_bits = mode_control[MODE_HIGH_LSB +: 2];
    assign output_polarity_select = mode_control[POLARITY_LSB +: 2];
    assign output_configuration = output_config_t'(mode_control[MODE_CFG_LSB +: 2]);
    assign steering_sync_select = steering_control[STEER_SYNC_BIT];
    assign pwm_on = (unit_mode_high_bits == PWM_MODE_HIGH);
    assign wr_shutdown = reg_write && (reg_addr == ADDR_SHUTDOWN_CONTROL);

    // Instruction-cycle tick, one clock in every four. Its phase runs free
    // from reset, so a dead band of n counts lasts exactly n instruction
    // cycles only when the PWM edges fall on tick boundaries.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tcy_count <= 2'h0;
        end else if (tcy_count == TCY_LAST) begin
            tcy_count <= 2'h0;
        end else begin
            tcy_count <= tcy_count + 2'h1;
        end
    end
    assign tcy_tick = (tcy_count == TCY_LAST);

    // Plain control registers; the status bit is kept separately.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shutdown_control <= RESET_SHUTDOWN_CONTROL;
            pwm_restart_deadband_control <= RESET_RESTART_DEADBAND;
            mode_control <= RESET_MODE_CONTROL;
            steering_control <= RESET_STEERING_CONTROL;
            comparator_two_sync <= RESET_SYNC_CONTROL[COMPARATOR_TWO_SYNC_BIT];
        end else if (reg_write) begin
            unique case (reg_addr)
                ADDR_SHUTDOWN_CONTROL: begin
                    shutdown_control <= reg_wdata;
                end
                ADDR_RESTART_DEADBAND: begin
                    pwm_restart_deadband_control <= reg_wdata;
                end
                ADDR_MODE_CONTROL: begin
                    mode_control <= reg_wdata;
                end
                ADDR_STEERING_CONTROL: begin
                    steering_control <= {3'h0, reg_wdata[4:0]};
                end
                ADDR_SYNC_CONTROL: begin
                    comparator_two_sync <= reg_wdata[COMPARATOR_TWO_SYNC_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Comparator two is resampled on the timer tick when sync is on.
    // A level caught by the tick stays held until the next tick, even
    // after the comparator itself has dropped.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comparator_two_held <= 1'b0;
        end else if (timer1_sync_tick) begin
            comparator_two_held <= comparator_two_out;
        end
    end
    assign comparator_two_eff = comparator_two_sync ? comparator_two_held : comparator_two_out;

    // Shutdown source decode; comparators count while their output is
    // high, the interrupt pin while it is low.
    always_comb begin
        source_hit = 1'b0;
        if (shutdown_source_select[0] && comparator_one_out) begin
            source_hit = 1'b1;
        end
        if (shutdown_source_select[1] && comparator_two_eff) begin
            source_hit = 1'b1;
        end
        if (shutdown_source_select[2] && !ext_interrupt_pin) begin
            source_hit = 1'b1;
        end
    end

    // Sticky status bit. A live source wins over any write, so clearing
    // is refused while the condition persists.
    // A firmware write of one is a shutdown event of its own; with auto
    // restart on it clears again in the following cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shutdown_event_status <= 1'b0;
        end else if (source_hit) begin
            shutdown_event_status <= 1'b1;
        end else if (wr_shutdown) begin
            shutdown_event_status <= reg_wdata[SD_STATUS_BIT];
        end else if (auto_restart_enable && shutdown_event_status) begin
            shutdown_event_status <= 1'b0;
        end
    end

    // The pins are forced with no clock in the path, from either the
    // live condition or the latched status.
    assign shutdown_now = source_hit || shutdown_event_status;

    // After a restart the outputs stay in shutdown state until the clock after
    // the next period_start, so the first clock of that period still shows shutdown.
    // Reset leaves it set, since the cleared mode register already keeps
    // every pin released until firmware selects a PWM mode.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_enabled <= 1'b1;
        end else if (shutdown_now) begin
            run_enabled <= 1'b0;
        end else if (period_start) begin
            run_enabled <= 1'b1;
        end
    end

    // Steering enables take effect in the second cycle after the writing cycle, or at the
    // next period start when synchronised steering is selected.
    // Synchronised steering switches one clock after period_start, so that clock still follows the old enables.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            steer_active <= RESET_STEERING_CONTROL[STEER_EN_LSB +: 4];
        end else if (!steering_sync_select) begin
            steer_active <= steering_control[STEER_EN_LSB +: 4];
        end else if (period_start) begin
            steer_active <= steering_control[STEER_EN_LSB +: 4];
        end
    end

    // Dead-band counters for the half-bridge pair; A follows the PWM and
    // B its complement.
    // A count longer than the active time reloads before reaching zero,
    // so that output stays inactive for the whole cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            delay_a <= 7'h00;
            delay_b <= 7'h00;
        end else begin
            delay_a <= next_delay(pwm_raw, tcy_tick, delay_a, dead_band_count);
            delay_b <= next_delay(!pwm_raw, tcy_tick, delay_b, dead_band_count);
        end
    end

    // Per-pin use and active state for each output configuration.
    always_comb begin
        pin_used = 4'h0;
        pin_active = 4'h0;
        unique case (output_configuration)
            CFG_SINGLE: begin
                pin_used = steer_active;
                pin_active = {4{pwm_raw}};
            end
            CFG_HALF: begin
                pin_used = 4'h3;
                // Rising edges wait out the count; falling edges are at once.
                pin_active[0] = pwm_raw && (delay_a == 7'h00);
                pin_active[1] = !pwm_raw && (delay_b == 7'h00);
            end
            CFG_FULL_FWD: begin
                pin_used = 4'hf;
                pin_active[0] = 1'b1;
                pin_active[3] = pwm_raw;
            end
            CFG_FULL_REV: begin
                pin_used = 4'hf;
                pin_active[2] = 1'b1;
                pin_active[1] = pwm_raw;
            end
        endcase
    end

    // Pin drivers. Unused pins are released to the port; used pins show
    // the PWM with pair polarity, or their pair's shutdown state.
    // A shutdown never touches a pin outside the mode or the steering,
    // so any other function sharing that pin keeps working.
    always_comb begin
        logic [1:0] drive;
        logic low_pol;
        drive = 2'h0;
        low_pol = 1'b0;
        pin_level = 4'h0;
        pin_oe_n = 4'hf;
        for (int i = 0; i < 4; i++) begin
            low_pol = (i % 2 == 0) ? output_polarity_select[1] : output_polarity_select[0];
            if (pwm_on && pin_used[i]) begin
                if (shutdown_now || !run_enabled) begin
                    if (i % 2 == 0) begin
                        drive = shutdown_drive(pair_ac_shutdown_state);
                    end else begin
                        drive = shutdown_drive(pair_bd_shutdown_state);
                    end
                    pin_level[i] = drive[0] && !drive[1];
                    pin_oe_n[i] = drive[1];
                end else begin
                    pin_level[i] = pin_active[i] ^ low_pol;
                    pin_oe_n[i] = 1'b0;
                end
            end
        end
    end

    assign pwm_out_a = pin_level[0];
    assign pwm_out_b = pin_level[1];
    assign pwm_out_c = pin_level[2];
    assign pwm_out_d = pin_level[3];
    assign pwm_out_a_oe_n = pin_oe_n[0];
    assign pwm_out_b_oe_n = pin_oe_n[1];
    assign pwm_out_c_oe_n = pin_oe_n[2];
    assign pwm_out_d_oe_n = pin_oe_n[3];

    // Read data appear in the cycle after the read strobe only.
    // The live status bit is merged into the shutdown control byte, and
    // unmapped addresses read as zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_SHUTDOWN_CONTROL: begin
                    reg_rdata <= {shutdown_event_status, shutdown_control[6:0]};
                end
                ADDR_RESTART_DEADBAND: begin
                    reg_rdata <= pwm_restart_deadband_control;
                end
                ADDR_MODE_CONTROL: begin
                    reg_rdata <= mode_control;
                end
                ADDR_STEERING_CONTROL: begin
                    reg_rdata <= steering_control;
                end
                ADDR_SYNC_CONTROL: begin
                    reg_rdata <= {7'h00, comparator_two_sync};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : pwm_output_stage

`default_nettype wire

// *** src/pwm_stage_pkg.sv ***
// Constants for the PWM output stage: register map, field positions,
// reset values, mode encodings and instruction-cycle timing.
// Assumes the block clock is the oscillator clock (Tosc) at 200 MHz.
package pwm_stage_pkg;

    // Register bus widths.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets on the plain register port.
    localparam logic [2:0] ADDR_SHUTDOWN_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RESTART_DEADBAND = 3'h1;
    localparam logic [2:0] ADDR_MODE_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_STEERING_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_SYNC_CONTROL = 3'h4;

    // Reset values.
    localparam logic [7:0] RESET_SHUTDOWN_CONTROL = 8'h00;
    localparam logic [7:0] RESET_RESTART_DEADBAND = 8'h00;
    localparam logic [7:0] RESET_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RESET_STEERING_CONTROL = 8'h01;
    localparam logic [7:0] RESET_SYNC_CONTROL = 8'h00;

    // Field positions.
    localparam int SD_STATUS_BIT = 7;
    localparam int SD_SELECT_LSB = 4;
    localparam int PAIR_AC_LSB = 2;
    localparam int PAIR_BD_LSB = 0;
    localparam int RESTART_BIT = 7;
    localparam int DEADBAND_LSB = 0;
    localparam int MODE_CFG_LSB = 6;
    localparam int MODE_HIGH_LSB = 2;
    localparam int POLARITY_LSB = 0;
    localparam int STEER_SYNC_BIT = 4;
    localparam int STEER_EN_LSB = 0;
    localparam int COMPARATOR_TWO_SYNC_BIT = 0;

    // Mode high bits that select the enhanced PWM function.
    localparam logic [1:0] PWM_MODE_HIGH = 2'h3;

    // Output configuration encodings.
    typedef enum logic [1:0] {
        CFG_SINGLE = 2'b00,
        CFG_FULL_FWD = 2'b01,
        CFG_HALF = 2'b10,
        CFG_FULL_REV = 2'b11
    } output_config_t;

    // Instruction cycle is four oscillator periods.
    localparam int CLK_PERIOD_NS = 5;
    localparam int TOSC_NS = 5;
    localparam int TCY_NS = 4 * TOSC_NS;
    localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] TCY_LAST = 2'(TCY_CYCLES - 1);

endpackage : pwm_stage_pkg

// *** verification/pwm_output_stage_assertions.sv ***
// Checker for the PWM output stage, bound to the stage's ports.
// Assumes the package register map and the active-high half bridge code 8'h8c.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_stage_assertions
    import pwm_stage_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic period_start,
    input wire logic comparator_one_out,
    input wire logic comparator_two_out,
    input wire logic ext_interrupt_pin,
    input wire logic pwm_out_a,
    input wire logic pwm_out_a_oe_n,
    input wire logic pwm_out_b,
    input wire logic pwm_out_b_oe_n,
    input wire logic pwm_out_c_oe_n,
    input wire logic pwm_out_d_oe_n
);
    logic [6:0] sd;
    logic [7:0] mode;
    logic c2s;
    logic src;
    logic half;

    // Shadow copies of the written fields that the properties depend on.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sd <= 7'h00;
            mode <= 8'h00;
            c2s <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == ADDR_SHUTDOWN_CONTROL) sd <= reg_wdata[6:0];
            if (reg_addr == ADDR_MODE_CONTROL) mode <= reg_wdata;
            if (reg_addr == ADDR_SYNC_CONTROL) c2s <= reg_wdata[0];
        end
    end

    // Sources that force the pins at once; synced comparator two is left out.
    assign src = (sd[4] && comparator_one_out) || (sd[5] && comparator_two_out && !c2s)
        || (sd[6] && !ext_interrupt_pin);
    assign half = (mode == 8'h8c);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Pin A taken back into drive from a released shutdown state, with a quiet bus.
    sequence a_back;
        $fell(pwm_out_a_oe_n) && sd[3] && !$past(reg_write) && !$past(reg_write, 2)
            && !$past(reg_write, 3);
    endsequence

    chk_ac_float: assert property (src && sd[3] |-> pwm_out_a_oe_n && pwm_out_c_oe_n)
        else $error("pair ac driven in float state");
    chk_ac_low: assert property (src && sd[3:2] == 2'h0 |-> pwm_out_a_oe_n || !pwm_out_a)
        else $error("pin a not forced low");
    chk_bd_high: assert property (src && sd[1:0] == 2'h1 |-> pwm_out_b_oe_n || pwm_out_b)
        else $error("pin b not forced high");
    chk_status_held: assert property (reg_read && reg_addr == ADDR_SHUTDOWN_CONTROL
        && src && $past(src) |=> reg_rdata[7])
        else $error("status clear while source held");
    chk_unmapped_zero: assert property (reg_read && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_resume_period: assert property (a_back |-> $past(period_start))
        else $error("pin a resumed off period start");
    chk_half_apart: assert property (half && sd[3:2] != 2'h1 && sd[1:0] != 2'h1
        |-> !(pwm_out_a && pwm_out_b))
        else $error("half bridge outputs overlap");
    chk_half_pins: assert property (half && $stable(mode)
        |-> pwm_out_c_oe_n && pwm_out_d_oe_n)
        else $error("half bridge drives c or d");
endmodule : pwm_output_stage_assertions

bind pwm_output_stage pwm_output_stage_assertions chk_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .period_start(period_start), .comparator_one_out(comparator_one_out),
    .comparator_two_out(comparator_two_out), .ext_interrupt_pin(ext_interrupt_pin),
    .pwm_out_a(pwm_out_a), .pwm_out_a_oe_n(pwm_out_a_oe_n), .pwm_out_b(pwm_out_b),
    .pwm_out_b_oe_n(pwm_out_b_oe_n), .pwm_out_c_oe_n(pwm_out_c_oe_n),
    .pwm_out_d_oe_n(pwm_out_d_oe_n)
);
`default_nettype wire

// *** verification/bridge_switch_model.sv ***
// Model of the four bridge switches that the PWM pins drive.
// Assumes a pull-down on every pin, so a released pin turns its switch off.
`timescale 1ns/1ps
`default_nettype none
module bridge_switch_model (
    input wire logic [3:0] pin_level,
    input wire logic [3:0] pin_oe_n,
    output logic [3:0] switch_on,
    output logic shoot_through
);
    // A switch conducts only while its pin is driven high.
    assign switch_on = ~pin_oe_n & pin_level;
    // Upper switch on A and lower switch on B conducting together is a short.
    assign shoot_through = switch_on[0] & switch_on[1];
endmodule : bridge_switch_model
`default_nettype wire

// *** verification/tb_pwm_output_stage.sv ***
// Testbench for the PWM output stage: registers, shutdown, restart, steering, dead band.
// Assumes a 64-clock PWM period made here, with pwm_raw high for its first 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_output_stage
    import pwm_stage_pkg::*;
;
    logic clk, resetn, reg_write, reg_read, pwm_raw, period_start;
    logic c1, c2, tick, ext, acc, hit;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, sc;
    logic [5:0] pcnt;
    wire [7:0] reg_rdata;
    wire [3:0] lvl, oe_n, sw_on;
    wire shoot;
    int bad_count, cmp_count;
    logic [7:0] rv [6] = '{RESET_SHUTDOWN_CONTROL, RESET_RESTART_DEADBAND,
        RESET_MODE_CONTROL, RESET_STEERING_CONTROL, RESET_SYNC_CONTROL, 8'h00};

    pwm_output_stage dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pwm_raw(pwm_raw), .period_start(period_start), .comparator_one_out(c1),
        .comparator_two_out(c2), .timer1_sync_tick(tick), .ext_interrupt_pin(ext),
        .pwm_out_a(lvl[0]), .pwm_out_a_oe_n(oe_n[0]), .pwm_out_b(lvl[1]),
        .pwm_out_b_oe_n(oe_n[1]), .pwm_out_c(lvl[2]), .pwm_out_c_oe_n(oe_n[2]),
        .pwm_out_d(lvl[3]), .pwm_out_d_oe_n(oe_n[3])
    );
    bridge_switch_model bridge (.pin_level(lvl), .pin_oe_n(oe_n), .switch_on(sw_on),
        .shoot_through(shoot));

    // Clock of 5 ns period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Stands in for the period and duty generator.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pcnt <= 6'h00;
            pwm_raw <= 1'b0;
            period_start <= 1'b0;
        end else begin
            pcnt <= pcnt + 6'h01;
            period_start <= (pcnt == 6'h3f);
            pwm_raw <= (pcnt == 6'h3f) || (pcnt < 6'h0f);
        end
    end

    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // One-cycle register read; the data stand in the following cycle only.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // Lets n edges pass and settles past the last one.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Waits for a phase of the PWM period.
    task automatic wait_cnt(input logic [5:0] n);
        do step(1); while (pcnt !== n);
    endtask : wait_cnt

    // Asserts or removes one shutdown source; the interrupt pin is active low.
    task automatic drive(input int k, input logic v);
        @(posedge clk);
        if (k == 0) c1 <= v;
        else if (k == 1) c2 <= v;
        else ext <= !v;
        #1;
    endtask : drive

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // Cuts a hang short; the sequence needs well under 20000 clocks.
    initial begin
        #100000;
        bad_count++;
        test_done();
    end

    // Main sequence.
    initial begin
        resetn = 1'b0;
        {reg_write, reg_read, c1, c2, tick} = 5'h00;
        ext = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        step(1);
        chk({oe_n, lvl}, 8'hf0);
        foreach (rv[i]) rd(3'(i), rv[i]);
        wr(ADDR_RESTART_DEADBAND, 8'hff);
        rd(ADDR_RESTART_DEADBAND, 8'hff);
        wr(ADDR_RESTART_DEADBAND, 8'h00);
        wr(ADDR_STEERING_CONTROL, 8'hef);
        rd(ADDR_STEERING_CONTROL, 8'h0f);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_MODE_CONTROL, 8'h0c | 8'(p));
            step(2);
            chk({oe_n, lvl}, {4'h0, {4{pwm_raw}} ^ {p[0], p[1], p[0], p[1]}});
        end
        wr(ADDR_MODE_CONTROL, 8'h4c);
        wait_cnt(6'h14);
        chk({oe_n, lvl}, 8'h01);
        wait_cnt(6'h00);
        chk({oe_n, lvl}, 8'h09);
        wr(ADDR_MODE_CONTROL, 8'hcc);
        wait_cnt(6'h05);
        chk({oe_n, lvl}, 8'h06);
        wait_cnt(6'h14);
        chk({oe_n, lvl}, 8'h04);
        wr(ADDR_MODE_CONTROL, 8'h0c);
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 3; k++) begin
                hit = s[k];
                sc = {1'b0, 3'(s), 4'h4};
                wr(ADDR_SHUTDOWN_CONTROL, sc);
                wait_cnt(6'h14);
                drive(k, 1'b1);
                chk({oe_n, lvl}, hit ? 8'h05 : 8'h00);
                rd(ADDR_SHUTDOWN_CONTROL, sc | {hit, 7'h00});
                wr(ADDR_SHUTDOWN_CONTROL, sc);
                rd(ADDR_SHUTDOWN_CONTROL, sc | {hit, 7'h00});
                drive(k, 1'b0);
                rd(ADDR_SHUTDOWN_CONTROL, sc | {hit, 7'h00});
                wr(ADDR_SHUTDOWN_CONTROL, sc);
                wait_cnt(6'h00);
                chk({oe_n, lvl}, hit ? 8'h05 : 8'h0f);
                step(1);
                chk({oe_n, lvl}, 8'h0f);
            end
        end
        wr(ADDR_SHUTDOWN_CONTROL, 8'h84);
        step(1);
        chk({oe_n, lvl}, 8'h05);
        rd(ADDR_SHUTDOWN_CONTROL, 8'h84);
        wr(ADDR_SHUTDOWN_CONTROL, 8'h04);
        wait_cnt(6'h00);
        step(1);
        chk({oe_n, lvl}, 8'h0f);
        wr(ADDR_RESTART_DEADBAND, 8'h80);
        wr(ADDR_SHUTDOWN_CONTROL, 8'h14);
        wait_cnt(6'h14);
        drive(0, 1'b1);
        step(3);
        rd(ADDR_SHUTDOWN_CONTROL, 8'h94);
        drive(0, 1'b0);
        step(2);
        rd(ADDR_SHUTDOWN_CONTROL, 8'h14);
        chk({oe_n, lvl}, 8'h05);
        wait_cnt(6'h00);
        step(1);
        chk({oe_n, lvl}, 8'h0f);
        wr(ADDR_STEERING_CONTROL, 8'h03);
        wr(ADDR_SHUTDOWN_CONTROL, 8'h19);
        step(1);
        chk({4'h0, oe_n}, 8'h0c);
        wait_cnt(6'h14);
        drive(0, 1'b1);
        chk({oe_n, lvl}, 8'hd2);
        chk({4'h0, sw_on}, 8'h02);
        drive(0, 1'b0);
        wait_cnt(6'h00);
        step(1);
        chk({oe_n, lvl}, 8'hc3);
        wr(ADDR_STEERING_CONTROL, 8'h1f);
        step(2);
        chk({4'h0, oe_n}, 8'h0c);
        wait_cnt(6'h00);
        step(2);
        chk({4'h0, oe_n}, 8'h00);
        wr(ADDR_SYNC_CONTROL, 8'h01);
        wr(ADDR_SHUTDOWN_CONTROL, 8'h24);
        wait_cnt(6'h14);
        drive(1, 1'b1);
        step(3);
        chk({oe_n, lvl}, 8'h00);
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        step(2);
        chk({oe_n, lvl}, 8'h05);
        drive(1, 1'b0);
        wr(ADDR_SHUTDOWN_CONTROL, 8'h00);
        wr(ADDR_RESTART_DEADBAND, 8'h00);
        wr(ADDR_MODE_CONTROL, 8'h8c);
        wait_cnt(6'h00);
        step(3);
        chk({oe_n, lvl}, 8'hc1);
        wait_cnt(6'h14);
        chk({oe_n, lvl}, 8'hc2);
        wr(ADDR_RESTART_DEADBAND, 8'h02);
        wait_cnt(6'h00);
        step(3);
        chk({oe_n, lvl}, 8'hc0);
        step(10);
        chk({oe_n, lvl}, 8'hc1);
        wait_cnt(6'h14);
        chk({oe_n, lvl}, 8'hc0);
        step(10);
        chk({oe_n, lvl}, 8'hc2);
        wr(ADDR_RESTART_DEADBAND, 8'h06);
        wait_cnt(6'h00);
        acc = 1'b0;
        repeat (20) begin
            step(1);
            acc = acc | lvl[0] | shoot;
        end
        chk({7'h00, acc}, 8'h00);
        test_done();
    end
endmodule : tb_pwm_output_stage
`default_nettype wire
